// ---- inc/fls_pkg.sv ----
// constants shared by the flash lock, margin and status logic
`default_nettype none
package fls_pkg;
   // ------------------------------------------------------------
   // bus geometry
   // ------------------------------------------------------------
   localparam int unsigned    FLS_DATA_W        = 32;
   localparam int unsigned    FLS_ADDR_W        = 8;
   localparam logic [1:0]     FLS_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0]     FLS_HTRANS_SEQ    = 2'h3;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0]     FLS_OFS_STATUS_LOCK = 8'h00;
   localparam logic [7:0]     FLS_OFS_MARGIN_READ = 8'h04;
   localparam logic [7:0]     FLS_OFS_IRQ_STATUS  = 8'h08;
   localparam logic [7:0]     FLS_OFS_IRQ_CLEAR   = 8'h0c;
   localparam logic [7:0]     FLS_OFS_IRQ_ENABLE  = 8'h10;

   // ------------------------------------------------------------
   // password byte, bits 15-8 of both control registers
   // ------------------------------------------------------------
   localparam int unsigned    FLS_KEY_LSB   = 8;
   localparam logic [7:0]     FLS_KEY_READ  = 8'h96;
   localparam logic [7:0]     FLS_KEY_WRITE = 8'ha5;

   // ------------------------------------------------------------
   // status and lock register fields
   // ------------------------------------------------------------
   localparam int unsigned    FLS_BIT_INFO_LOCK  = 6;
   localparam int unsigned    FLS_BIT_EMERGENCY_EXIT       = 5;
   localparam int unsigned    FLS_BIT_LOCK       = 4;
   localparam int unsigned    FLS_BIT_WRITE_RDY  = 3;
   localparam int unsigned    FLS_BIT_ACC_VIOL   = 2;
   localparam int unsigned    FLS_BIT_KEY_VIOL   = 1;
   localparam int unsigned    FLS_BIT_BUSY       = 0;
   localparam logic           FLS_RST_INFO_LOCK  = 1'b1;
   localparam logic           FLS_RST_EMERGENCY_EXIT       = 1'b0;
   localparam logic           FLS_RST_LOCK       = 1'b1;
   localparam logic           FLS_RST_WRITE_RDY  = 1'b1;
   localparam logic           FLS_RST_ACC_VIOL   = 1'b0;
   localparam logic           FLS_RST_KEY_VIOL   = 1'b0;

   // ------------------------------------------------------------
   // margin read register fields
   // ------------------------------------------------------------
   localparam int unsigned    FLS_BIT_MRG_ONE  = 5;
   localparam int unsigned    FLS_BIT_MRG_ZERO = 4;
   localparam logic           FLS_RST_MRG      = 1'b0;

   // ------------------------------------------------------------
   // interrupt status layout
   // ------------------------------------------------------------
   localparam int unsigned    FLS_IRQ_W        = 3;
   localparam int unsigned    FLS_IRQ_ACC_VIOL = 0;
   localparam int unsigned    FLS_IRQ_KEY_VIOL = 1;
   localparam int unsigned    FLS_IRQ_OP_DONE  = 2;
   localparam logic [2:0]     FLS_RST_IRQ      = 3'h0;

   typedef enum logic {
      FLS_BUS_IDLE,
      FLS_BUS_READ_WAIT
   } fls_bus_state_t;
endpackage
`default_nettype wire

// ---- logic/fls_ahb_front.sv ----
// ahb-lite address phase capture and ready generation
`timescale 1ns/10ps
`default_nettype none
module fls_ahb_front (
   input  wire  logic                            hclk,
   input  wire  logic                            hresetn,
   input  wire  logic                            hsel,
   input  wire  logic [fls_pkg::FLS_DATA_W-1:0]  haddr,
   input  wire  logic [1:0]                      htrans,
   input  wire  logic                            hwrite,
   input  wire  logic                            hready,
   output var   logic                            hreadyout,
   output var   logic                            wr_stb,
   output var   logic                            rd_stb,
   output var   logic [fls_pkg::FLS_ADDR_W-1:0]  acc_addr
);
   import fls_pkg::*;

   fls_bus_state_t               state_q;
   logic                         start;

   assign start = hsel & hready & (htrans == FLS_HTRANS_NONSEQ || htrans == FLS_HTRANS_SEQ);

   // ------------------------------------------------------------
   // address phase
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_addr <= 8'h00;
         wr_stb   <= 1'b0;
      end else begin
         wr_stb <= start & hwrite;
         if (start) begin
            acc_addr <= haddr[FLS_ADDR_W-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // one wait state on reads
   // ------------------------------------------------------------
   // the wait lets a write still in its data phase land before the read is sampled
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q   <= FLS_BUS_IDLE;
         hreadyout <= 1'b1;
      end else begin
         unique case (state_q)
            FLS_BUS_IDLE: begin
               if (start && !hwrite) begin
                  state_q   <= FLS_BUS_READ_WAIT;
                  hreadyout <= 1'b0;
               end
            end
            FLS_BUS_READ_WAIT: begin
               state_q   <= FLS_BUS_IDLE;
               hreadyout <= 1'b1;
            end
         endcase
      end
   end

   assign rd_stb = (state_q == FLS_BUS_READ_WAIT);
endmodule
`default_nettype wire

// ---- logic/fls_lock_margin_status.sv ----
// flash lock, margin read and status control with ahb-lite register access
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// R01: writing 1 to the info segment lock toggles it; writing 0 does nothing
// R02: info lock clear: mass erase also erases protected and information segments
// R03: info lock set: mass erase spares protected and information segments
// R04: lock bit blocks write and erase; a running operation still finishes
// R05: lock set during block write with ready: clear ready, end block write
// R06: write ready reads 1 when the flash accepts the next write
// R07: access violation flag reads 1 while that interrupt is pending; here a status write clears it; the interrupt clear does not
// R08: wrong password write sets key violation flag and pulses power up clear
// R09: key violation flag stays set until software clears it
// R10: busy reads 1 while the timing generator is active
// R11: password byte reads 96h; writes must carry a5h or reset follows
// R12: margin zero bit enables marginal 0 read; cleared on flash execution
// R13: both margin bits set: margin one wins, margin zero ignored
// R14: margin one bit enables marginal 1 read; cleared on flash execution
module fls_lock_margin_status (
   input  wire  logic                            hclk,
   input  wire  logic                            hresetn,
   input  wire  logic                            hsel,
   input  wire  logic [fls_pkg::FLS_DATA_W-1:0]  haddr,
   input  wire  logic [1:0]                      htrans,
   input  wire  logic                            hwrite,
   input  wire  logic [2:0]                      hsize,
   input  wire  logic [fls_pkg::FLS_DATA_W-1:0]  hwdata,
   input  wire  logic                            hready,
   output var   logic                            hreadyout,
   output var   logic                            hresp,
   output var   logic [fls_pkg::FLS_DATA_W-1:0]  hrdata,
   input  wire  logic                            ftg_busy,
   input  wire  logic                            ftg_ready,
   input  wire  logic                            block_write_mode,
   input  wire  logic                            access_violation_evt,
   input  wire  logic                            cpu_flash_fetch,
   output var   logic                            program_allow,
   output var   logic                            info_mass_erase_en,
   output var   logic                            block_write_end,
   output var   logic                            power_up_clear,
   output var   logic                            emergency_exit,
   output var   logic                            margin_zero_mode,
   output var   logic                            margin_one_mode,
   output var   logic                            irq
);
   import fls_pkg::*;

   // ------------------------------------------------------------
   // local signals
   // ------------------------------------------------------------
   logic                         wr_stb;
   logic                         rd_stb;
   logic [FLS_ADDR_W-1:0]        acc_addr;
   logic                         key_ok;
   logic                         wr_status;
   logic                         wr_margin;
   logic                         key_bad;
   logic                         lock_set_wr;
   logic                         block_abort;
   logic                         op_done;
   logic                         info_lock_q;
   logic                         info_lock_d;
   logic                         lock_q;
   logic                         lock_d;
   logic                         emergency_exit_q;
   logic                         write_rdy_q;
   logic                         abort_hold_q;
   logic                         acc_viol_q;
   logic                         key_viol_q;
   logic                         busy_q;
   logic                         mrg_zero_q;
   logic                         mrg_zero_d;
   logic                         mrg_one_q;
   logic                         mrg_one_d;
   logic [FLS_IRQ_W-1:0]         irq_stat_q;
   logic [FLS_IRQ_W-1:0]         irq_stat_d;
   logic [FLS_IRQ_W-1:0]         irq_en_q;
   logic [FLS_IRQ_W-1:0]         irq_en_d;
   logic [FLS_IRQ_W-1:0]         irq_evt;
   logic [FLS_IRQ_W-1:0]         irq_clr;

   // both control registers carry the password byte
   function automatic logic ctl_hit(input logic [FLS_ADDR_W-1:0] a);
      ctl_hit = (a == FLS_OFS_STATUS_LOCK) || (a == FLS_OFS_MARGIN_READ);
   endfunction

   // ------------------------------------------------------------
   // bus front end
   // ------------------------------------------------------------
   fls_ahb_front u_front (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hready    (hready),
      .hreadyout (hreadyout),
      .wr_stb    (wr_stb),
      .rd_stb    (rd_stb),
      .acc_addr  (acc_addr)
   );

   // ------------------------------------------------------------
   // write decode
   // ------------------------------------------------------------
   // size is not checked: only whole word accesses are supported
   assign key_ok    = (hwdata[FLS_KEY_LSB+7:FLS_KEY_LSB] == FLS_KEY_WRITE);            // [R11]
   assign key_bad   = wr_stb & ctl_hit(acc_addr) & ~key_ok;                            // [R08]
   assign wr_status = wr_stb & key_ok & (acc_addr == FLS_OFS_STATUS_LOCK);
   assign wr_margin = wr_stb & key_ok & (acc_addr == FLS_OFS_MARGIN_READ);
   assign irq_clr   = (wr_stb && acc_addr == FLS_OFS_IRQ_CLEAR) ?
                      hwdata[FLS_IRQ_W-1:0] : FLS_RST_IRQ;

   // ------------------------------------------------------------
   // lock bits
   // ------------------------------------------------------------
   always_comb begin
      info_lock_d = info_lock_q;
      if (wr_status && hwdata[FLS_BIT_INFO_LOCK]) begin
         info_lock_d = ~info_lock_q;                                                   // [R01]
      end
   end

   always_comb begin
      lock_d = lock_q;
      if (wr_status) begin
         lock_d = hwdata[FLS_BIT_LOCK];
      end
   end

   assign lock_set_wr = wr_status & hwdata[FLS_BIT_LOCK];
   assign block_abort = lock_set_wr & block_write_mode & write_rdy_q;                  // [R05]

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         info_lock_q <= FLS_RST_INFO_LOCK;
         lock_q      <= FLS_RST_LOCK;
         emergency_exit_q      <= FLS_RST_EMERGENCY_EXIT;
      end else begin
         info_lock_q <= info_lock_d;
         lock_q      <= lock_d;
         if (wr_status) begin
            emergency_exit_q <= hwdata[FLS_BIT_EMERGENCY_EXIT];
         end
      end
   end

   // ------------------------------------------------------------
   // erase and program permissions
   // ------------------------------------------------------------
   // an operation already running keeps its permission until busy drops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         program_allow      <= 1'b0;
         info_mass_erase_en <= 1'b0;
      end else begin
         program_allow      <= ~lock_d | (ftg_busy & program_allow);                   // [R04]
         info_mass_erase_en <= ~info_lock_d;                                           // [R02] [R03]
      end
   end

   // ------------------------------------------------------------
   // write ready and block write end
   // ------------------------------------------------------------
   // after an abort, ready stays low until block write mode is left
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         abort_hold_q    <= 1'b0;
         write_rdy_q     <= FLS_RST_WRITE_RDY;
         block_write_end <= 1'b0;
      end else begin
         if (block_abort) begin
            abort_hold_q <= 1'b1;
         end else if (!block_write_mode) begin
            abort_hold_q <= 1'b0;
         end
         write_rdy_q     <= ftg_ready & ~block_abort & ~abort_hold_q;                  // [R06] [R05]
         block_write_end <= block_abort;                                               // [R05]
      end
   end

   // ------------------------------------------------------------
   // violation flags and busy
   // ------------------------------------------------------------
   // hardware set beats a software clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_viol_q <= FLS_RST_ACC_VIOL;
         key_viol_q <= FLS_RST_KEY_VIOL;
         busy_q     <= 1'b0;
      end else begin
         busy_q <= ftg_busy;                                                           // [R10]
         if (access_violation_evt) begin
            acc_viol_q <= 1'b1;                                                        // [R07]
         end else if (wr_status) begin
            acc_viol_q <= hwdata[FLS_BIT_ACC_VIOL];
         end
         if (key_bad) begin
            key_viol_q <= 1'b1;                                                        // [R08]
         end else if (wr_status) begin
            key_viol_q <= hwdata[FLS_BIT_KEY_VIOL];                                    // [R09]
         end
      end
   end

   // the reset request lasts one cycle; the flag itself survives it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         power_up_clear <= 1'b0;
      end else begin
         power_up_clear <= key_bad;                                                    // [R08] [R11]
      end
   end

   // ------------------------------------------------------------
   // margin read control
   // ------------------------------------------------------------
   // flash execution start wins over a software write in the same cycle
   always_comb begin
      mrg_zero_d = mrg_zero_q;
      mrg_one_d  = mrg_one_q;
      if (cpu_flash_fetch) begin
         mrg_zero_d = 1'b0;                                                            // [R12]
         mrg_one_d  = 1'b0;                                                            // [R14]
      end else if (wr_margin) begin
         mrg_zero_d = hwdata[FLS_BIT_MRG_ZERO];
         mrg_one_d  = hwdata[FLS_BIT_MRG_ONE];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mrg_zero_q       <= FLS_RST_MRG;
         mrg_one_q        <= FLS_RST_MRG;
         margin_zero_mode <= 1'b0;
         margin_one_mode  <= 1'b0;
      end else begin
         mrg_zero_q       <= mrg_zero_d;
         mrg_one_q        <= mrg_one_d;
         margin_zero_mode <= mrg_zero_d & ~mrg_one_d;                                  // [R12] [R13]
         margin_one_mode  <= mrg_one_d;                                                // [R14] [R13]
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         emergency_exit <= 1'b0;
      end else begin
         emergency_exit <= wr_status ? hwdata[FLS_BIT_EMERGENCY_EXIT] : emergency_exit_q;
      end
   end

   // ------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------
   assign op_done = busy_q & ~ftg_busy;

   always_comb begin
      irq_evt                   = FLS_RST_IRQ;
      irq_evt[FLS_IRQ_ACC_VIOL] = access_violation_evt;
      irq_evt[FLS_IRQ_KEY_VIOL] = key_bad;
      irq_evt[FLS_IRQ_OP_DONE]  = op_done;
   end

   assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_evt;
   assign irq_en_d   = (wr_stb && acc_addr == FLS_OFS_IRQ_ENABLE) ?
                       hwdata[FLS_IRQ_W-1:0] : irq_en_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_q <= FLS_RST_IRQ;
         irq_en_q   <= FLS_RST_IRQ;
         irq        <= 1'b0;
      end else begin
         irq_stat_q <= irq_stat_d;
         irq_en_q   <= irq_en_d;
         irq        <= |(irq_stat_d & irq_en_d);
      end
   end

   // ------------------------------------------------------------
   // read data and response
   // ------------------------------------------------------------
   // unmapped offsets read as zero with an okay response
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
         hresp  <= 1'b0;
      end else if (rd_stb) begin
         hrdata <= 32'h0000_0000;
         unique case (acc_addr)
            FLS_OFS_STATUS_LOCK: begin
               hrdata[FLS_KEY_LSB+7:FLS_KEY_LSB] <= FLS_KEY_READ;                      // [R11]
               hrdata[FLS_BIT_INFO_LOCK]         <= info_lock_q;
               hrdata[FLS_BIT_EMERGENCY_EXIT]              <= emergency_exit_q;
               hrdata[FLS_BIT_LOCK]              <= lock_q;
               hrdata[FLS_BIT_WRITE_RDY]         <= write_rdy_q;                       // [R06]
               hrdata[FLS_BIT_ACC_VIOL]          <= acc_viol_q;                        // [R07]
               hrdata[FLS_BIT_KEY_VIOL]          <= key_viol_q;                        // [R09]
               hrdata[FLS_BIT_BUSY]              <= busy_q;                            // [R10]
            end
            FLS_OFS_MARGIN_READ: begin
               hrdata[FLS_KEY_LSB+7:FLS_KEY_LSB] <= FLS_KEY_READ;                      // [R11]
               hrdata[FLS_BIT_MRG_ONE]           <= mrg_one_q;
               hrdata[FLS_BIT_MRG_ZERO]          <= mrg_zero_q;
            end
            FLS_OFS_IRQ_STATUS: begin
               hrdata[FLS_IRQ_W-1:0] <= irq_stat_q;
            end
            FLS_OFS_IRQ_ENABLE: begin
               hrdata[FLS_IRQ_W-1:0] <= irq_en_q;
            end
            default: begin
               hrdata <= 32'h0000_0000;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- verif/fls_lock_margin_status_sva.sv ----
// assertion checker for the flash lock, margin and status block
`timescale 1ns/10ps
`default_nettype none
module fls_chk (
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       hsel,
   input wire logic [1:0] htrans,
   input wire logic       hwrite,
   input wire logic       hready,
   input wire logic       hreadyout,
   input wire logic       ftg_busy,
   input wire logic       cpu_flash_fetch,
   input wire logic       program_allow,
   input wire logic       block_write_end,
   input wire logic       power_up_clear,
   input wire logic       margin_zero_mode,
   input wire logic       margin_one_mode
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ----------------------------------------------------------
   // margin modes
   // ----------------------------------------------------------
   property p_mrg_excl; !(margin_zero_mode && margin_one_mode); endproperty
   a_mrg_excl: assert property (p_mrg_excl) else $error("margin modes both on");
   property p_fetch_clr;
      cpu_flash_fetch |-> ##[1:2] (!margin_zero_mode && !margin_one_mode);
   endproperty
   a_fetch_clr: assert property (p_fetch_clr) else $error("fetch left margin on");
   // ----------------------------------------------------------
   // bus timing
   // ----------------------------------------------------------
   property p_read_wait;
      hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
   property p_write_nowait; hsel && hready && htrans[1] && hwrite |=> hreadyout; endproperty
   a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
   // ----------------------------------------------------------
   // lock, reset request and block write
   // ----------------------------------------------------------
   property p_puc_pulse; power_up_clear |=> !power_up_clear; endproperty
   a_puc_pulse: assert property (p_puc_pulse) else $error("reset request too long");
   property p_puc_cause;
      $rose(power_up_clear) |-> $past(hsel && hready && htrans[1] && hwrite, 2);
   endproperty
   a_puc_cause: assert property (p_puc_cause) else $error("reset request w/o write");
   property p_busy_allow; program_allow && ftg_busy |=> program_allow; endproperty
   a_busy_allow: assert property (p_busy_allow) else $error("running op cut off");
   property p_bwe_pulse; block_write_end |=> !block_write_end; endproperty
   a_bwe_pulse: assert property (p_bwe_pulse) else $error("block end too long");
endmodule
bind fls_lock_margin_status fls_chk u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite,
   .hready, .hreadyout, .ftg_busy, .cpu_flash_fetch, .program_allow, .block_write_end,
   .power_up_clear, .margin_zero_mode, .margin_one_mode);
`default_nettype wire

// ---- verif/fls_lock_margin_status_tb_top.sv ----
// self-checking bench for the flash lock, margin and status block
`timescale 1ns/10ps
`default_nettype none
module fls_lock_margin_status_tb_top;
   import fls_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rv;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2;
   logic ftg_busy = 0, ftg_ready = 1, block_write_mode = 0, access_violation_evt = 0;
   logic cpu_flash_fetch = 0, program_allow, info_mass_erase_en, block_write_end;
   logic power_up_clear, emergency_exit, margin_zero_mode, margin_one_mode, irq;
   logic seen_bwe = 0, seen_puc = 0, b, r;
   int errors = 0, checks_done = 0, cyc = 0, i;
   int seed = 32'h7e227c4c;
   assign hready = hreadyout;
   fls_lock_margin_status uut (.*);
   initial forever #12.5 hclk = ~hclk;
   always @(posedge hclk) begin
      cyc++;
      if (block_write_end === 1'b1) seen_bwe = 1;
      if (power_up_clear === 1'b1) seen_puc = 1;
      if (cyc == 20000) begin
         errors++;
         finish_test();
      end
   end
   // ----------------------------------------------------------
   // bus tasks and expectations
   // ----------------------------------------------------------
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1; haddr <= {24'h0, a}; htrans <= FLS_HTRANS_NONSEQ; hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0; hsel <= 0; hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rv = hrdata;
      chk("hresp", hresp, 0);
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic [31:0] stat(logic il, lk, wr, av, kv, bz);
      return {16'h0, FLS_KEY_READ, 1'b0, il, 1'b0, lk, wr, av, kv, bz};
   endfunction
   // one-cycle event pulse: fetch start when fetch is set, access violation otherwise
   task automatic pulse(input bit fetch);
      @(posedge hclk) begin
         if (fetch) cpu_flash_fetch <= 1;
         else access_violation_evt <= 1;
      end
      @(posedge hclk) begin
         cpu_flash_fetch      <= 0;
         access_violation_evt <= 0;
      end
      repeat (3) @(posedge hclk);
   endtask
   task automatic finish_test();
      if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ----------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1;
      xfer(0, 8'h00, 0); chk("stat_rst", rv, stat(1, 1, 1, 0, 0, 0));
      xfer(0, 8'h04, 0); chk("mrg_rst", rv, 32'h9600);
      xfer(0, 8'h20, 0); chk("unmapped", rv, 32'h0);
      // info lock: toggle on 1, hold on 0
      xfer(1, 8'h00, 32'ha550); xfer(0, 8'h00, 0); chk("info_tog", rv, stat(0, 1, 1, 0, 0, 0));
      xfer(1, 8'h00, 32'ha510); xfer(0, 8'h00, 0); chk("info_hold", rv, stat(0, 1, 1, 0, 0, 0));
      chk("erase_all", info_mass_erase_en, 1);
      xfer(1, 8'h00, 32'ha550); repeat (2) @(posedge hclk);
      chk("erase_spare", info_mass_erase_en, 0);
      // lock during a running operation
      xfer(1, 8'h00, 32'ha500); repeat (2) @(posedge hclk);
      chk("allow", program_allow, 1);
      ftg_busy <= 1; xfer(1, 8'h00, 32'ha510); repeat (2) @(posedge hclk);
      chk("allow_busy", program_allow, 1);
      ftg_busy <= 0; repeat (3) @(posedge hclk);
      chk("locked", program_allow, 0);
      // random ready and busy levels
      for (i = 0; i < 12; i++) begin
         b = $random(seed); r = $random(seed);
         @(posedge hclk) begin ftg_busy <= b; ftg_ready <= r; end
         xfer(0, 8'h00, 0); chk("stat_rnd", rv, stat(1, 1, r, 0, 0, b));
      end
      ftg_busy <= 0; ftg_ready <= 1;
      // lock written during block write with ready
      block_write_mode <= 1; repeat (2) @(posedge hclk);
      xfer(1, 8'h00, 32'ha510); xfer(0, 8'h00, 0);
      chk("bw_wait", rv, stat(1, 1, 0, 0, 0, 0));
      chk("bw_end", seen_bwe, 1);
      block_write_mode <= 0; xfer(1, 8'h10, 32'h1);
      // access violation flag and interrupt, enabled then masked
      pulse(0); chk("irq_on", irq, 1);
      xfer(0, 8'h00, 0); chk("av_set", rv, stat(1, 1, 1, 1, 0, 0));
      xfer(1, 8'h00, 32'ha510); xfer(1, 8'h0c, 32'h7); repeat (2) @(posedge hclk);
      chk("irq_off", irq, 0);
      xfer(1, 8'h10, 32'h0); pulse(0); chk("irq_mask", irq, 0);
      xfer(0, 8'h08, 0); chk("irq_stat", rv[0], 1);
      xfer(1, 8'h00, 32'ha510);
      // wrong password: flag sticks, reset requested, content kept
      // bit 1 forced high so the random key can never match a5h
      xfer(1, 8'h00, {16'h0, 8'($random(seed)) | 8'h02, 8'h00});
      repeat (20) @(posedge hclk);
      chk("puc", seen_puc, 1);
      xfer(0, 8'h00, 0); chk("key_stick", rv, stat(1, 1, 1, 0, 1, 0));
      xfer(1, 8'h00, 32'ha510); xfer(0, 8'h00, 0);
      chk("key_clr", rv, stat(1, 1, 1, 0, 0, 0));
      // emergency exit bit: output follows the write, read back, then cleared
      xfer(1, 8'h00, 32'ha530); @(posedge hclk);
      chk("emergency_exit", emergency_exit, 1);
      xfer(0, 8'h00, 0); chk("emergency_exit_rd", rv, stat(1, 1, 1, 0, 0, 0) | 32'h20);
      xfer(1, 8'h00, 32'ha510);
      // margin bit combinations, then cleared by flash fetch
      for (i = 0; i < 4; i++) begin
         xfer(1, 8'h04, 32'ha500 | (i << 4)); repeat (2) @(posedge hclk);
         chk("mz", margin_zero_mode, i == 1);
         chk("mo", margin_one_mode, i >= 2);
         xfer(0, 8'h04, 0); chk("mrg_rd", rv, 32'h9600 | (i << 4));
      end
      pulse(1); xfer(0, 8'h04, 0); chk("mrg_clr", rv, 32'h9600);
      chk("emergency_exit_off", emergency_exit, 0);
      finish_test();
   end
endmodule
`default_nettype wire
